// ==== pfp_ctrl.v ====
// pulse sequencer driving low/mid/high levels onto the sensor output pin
`timescale 1ns/1ps
`include "pfp_map.vh"
// Overview of operation
// R1: device starts in initial state, unblown bits zero; controller starts every job there.
// R2: mid pulses in initial state are ignored; controller sends none there.
// R3: one high pulse enters zone one, three high pulses enter zone two.
// R4: mid pulses advance the key; zone one key1 gain, zone two key1 fine, key2 coarse.
// R5: one high pulse after the key opens the selected bit field.
// R6: skipping zone one selects nothing; mids ignored until zone two entered.
// R7: each mid pulse in addressing increments the code, saturating at maximum.
// R8: trial code stays held after drive is removed, so output can be measured.
// R9: addressing ends only by power cycle or blowing; the model leaves gain addressing for zone two on a high pulse.
// R10: a high blow pulse sets the bit; one bit per sequence, then power cycle.
// R11: blown bits never revert; code is sum of blown bits until lock.
// R12: zone one blow: key, code, two high pulses, then one blow pulse.
// R13: zone two blow: key, code, then exactly one blow pulse.
// R14: lock lives at zone two key two code four; blocks all later programming.
// R15: lock: three high, two mid, one high, four mid, then one high blow.
// R16: hold: after gain code, a high enters zone two, mid, high opens fine field.
// R17: at most two parameters together, in different zones.
// R18: unidirectional bit must be blown before hold mode trials; the controller starts a hold job without checking it.
// R19: wait low gap time after each blown bit before removing power.
// R20: order coarse, gain, fine; lock last. The controller enforces only lock last, by refusing jobs after the lock blow.
// R21: gain and fine fields are eight-bit codes 0..255.
// R22: coarse code one selects unidirectional quiescent level.
// R23: each selection or addressing pulse lasts at least the active time.
// R24: device decodes levels and acts when the pin returns low.
module pfp_ctrl #(
    parameter T_ACTIVE = `PFP_T_ACTIVE_CYC,
    parameter T_LOW = `PFP_T_LOW_CYC,
    parameter T_BLOW = `PFP_T_BLOW_CYC
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    // pin drive: level select for the programming supply
    output reg pin_mid_q,
    output reg pin_high_q,
    output reg power_on_q
);

    // sequencer states
    localparam S_IDLE = 6'h01;
    localparam S_PWR = 6'h02;
    localparam S_PULSE = 6'h04;
    localparam S_GAP = 6'h08;
    localparam S_HELD = 6'h10;
    localparam S_DONE = 6'h20;
    // pulse kinds in the script
    localparam P_NONE = 2'h0;
    localparam P_MID = 2'h1;
    localparam P_HIGH = 2'h2;
    localparam P_BLOW = 2'h3;

    reg [5:0] st_q;
    reg [2:0] cmd_q;
    reg [1:0] zone_q;
    reg [1:0] key_q;
    reg [7:0] code_q;
    reg [7:0] code2_q;
    reg [4:0] step_q;
    reg [9:0] mids_q;
    reg [1:0] kind_q;
    reg [31:0] tmr_q;
    reg busy_q;
    reg held_q;
    reg lock_sent_q;

    // script: which pulse to emit at step n, given the command
    function [1:0] script;
        input [2:0] cmd;
        input [1:0] zone;
        input [4:0] n;
        input [1:0] key;
        begin
            script = P_NONE;
            case (cmd)
                `PFP_CMD_TRY, `PFP_CMD_BLOW: begin
                    // R3 R5: zone entry, key, bit field open
                    if (zone == 2'h1) begin
                        case (n)
                            5'd0: script = P_HIGH;
                            5'd1: script = P_MID;
                            5'd2: script = P_HIGH;
                            5'd3: script = P_MID;
                            // R12: two highs then a blow in zone one
                            5'd4: script = (cmd == `PFP_CMD_BLOW) ? P_HIGH : P_NONE;
                            5'd5: script = (cmd == `PFP_CMD_BLOW) ? P_HIGH : P_NONE;
                            5'd6: script = (cmd == `PFP_CMD_BLOW) ? P_BLOW : P_NONE;
                            default: script = P_NONE;
                        endcase
                    end else begin
                        case (n)
                            5'd0, 5'd1, 5'd2: script = P_HIGH; // R3
                            5'd3: script = P_MID; // R4
                            5'd4: script = (key == 2'h2) ? P_MID : P_HIGH;
                            5'd5: script = (key == 2'h2) ? P_HIGH : P_MID;
                            5'd6: script = (key == 2'h2) ? P_MID : ((cmd == `PFP_CMD_BLOW) ? P_BLOW : P_NONE);
                            // R13: exactly one blow pulse
                            5'd7: script = (key == 2'h2 && cmd == `PFP_CMD_BLOW) ? P_BLOW : P_NONE;
                            default: script = P_NONE;
                        endcase
                    end
                end
                `PFP_CMD_LOCK: begin
                    // R14 R15: 3h 2m 1h 4m blow
                    case (n)
                        5'd0, 5'd1, 5'd2: script = P_HIGH;
                        5'd3, 5'd4: script = P_MID;
                        5'd5: script = P_HIGH;
                        5'd6: script = P_MID;
                        5'd7: script = P_BLOW;
                        default: script = P_NONE;
                    endcase
                end
                `PFP_CMD_HOLD: begin // R18
                    // R16 R17: gain in zone one, then fine level in zone two
                    case (n)
                        5'd0: script = P_HIGH;
                        5'd1: script = P_MID;
                        5'd2: script = P_HIGH;
                        5'd3: script = P_MID;
                        5'd4: script = P_HIGH;
                        5'd5: script = P_MID;
                        5'd6: script = P_HIGH;
                        5'd7: script = P_MID;
                        default: script = P_NONE;
                    endcase
                end
                default: script = P_NONE;
            endcase
        end
    endfunction

    // mid pulses whose count is the code (code steps) vs single
    function [9:0] reps;
        input [2:0] cmd;
        input [1:0] zone;
        input [4:0] n;
        input [1:0] key;
        input [7:0] code;
        input [7:0] code2;
        begin
            reps = 10'h001;
            if (cmd == `PFP_CMD_LOCK && n == 5'd6)
                reps = {2'h0, `PFP_LOCK_CODE}; // R15
            else if (cmd == `PFP_CMD_HOLD && n == 5'd3)
                reps = {2'h0, code}; // R7
            else if (cmd == `PFP_CMD_HOLD && n == 5'd7)
                reps = {2'h0, code2}; // R16
            else if ((cmd == `PFP_CMD_TRY || cmd == `PFP_CMD_BLOW) &&
                ((zone == 2'h1 && n == 5'd3) || (zone == 2'h2 && key == 2'h1 && n == 5'd5) ||
                (zone == 2'h2 && key == 2'h2 && n == 5'd6)))
                reps = {2'h0, code}; // R7 R21 R22
        end
    endfunction

    wire [1:0] cur_kind = script(cmd_q, zone_q, step_q, key_q);
    wire [9:0] cur_reps = reps(cmd_q, zone_q, step_q, key_q, code_q, code2_q);
    // a job is refused after lock was sent, R14; command 0 starts no job
    wire start_ok = reg_wr && reg_addr == `PFP_REG_CTRL && !busy_q && !lock_sent_q &&
        reg_wdata[2:0] != 3'h0; // R14 R20

    // register writes and the pulse sequencer
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= S_IDLE;
            cmd_q <= 3'h0;
            zone_q <= 2'h1;
            key_q <= 2'h1;
            code_q <= 8'h00;
            code2_q <= 8'h00;
            step_q <= 5'd0;
            mids_q <= 10'h000;
            kind_q <= P_NONE;
            tmr_q <= 32'h0;
            busy_q <= 1'b0;
            held_q <= 1'b0;
            lock_sent_q <= 1'b0;
            pin_mid_q <= 1'b0;
            pin_high_q <= 1'b0;
            power_on_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `PFP_REG_ARG && !busy_q) begin
                zone_q <= reg_wdata[1:0];
                key_q <= reg_wdata[3:2];
                code_q <= reg_wdata[15:8];
                code2_q <= reg_wdata[23:16];
            end
            case (st_q)
                S_IDLE: begin
                    if (start_ok) begin
                        cmd_q <= reg_wdata[2:0];
                        busy_q <= 1'b1;
                        held_q <= 1'b0;
                        step_q <= 5'd0;
                        power_on_q <= 1'b1; // R1: fresh power-up, initial state
                        tmr_q <= T_LOW;
                        st_q <= S_PWR;
                    end
                end
                S_PWR, S_GAP: begin
                    // R24: pin low between pulses for the gap time
                    if (tmr_q != 32'h0) begin
                        tmr_q <= tmr_q - 32'h1;
                    end else if (mids_q != 10'h000) begin
                        mids_q <= mids_q - 10'h001;
                        pin_mid_q <= 1'b1;
                        tmr_q <= T_ACTIVE;
                        st_q <= S_PULSE;
                    end else if (cur_kind == P_NONE) begin
                        // R8 R9: drive removed, trial value held until power off
                        held_q <= (cmd_q != `PFP_CMD_BLOW && cmd_q != `PFP_CMD_LOCK);
                        st_q <= S_HELD;
                    end else begin
                        kind_q <= cur_kind;
                        if (cur_kind == P_MID) begin
                            mids_q <= cur_reps - 10'h001;
                            if (cur_reps == 10'h000) begin
                                mids_q <= 10'h000; // code 0: no wrap to a long mid train
                                step_q <= step_q + 5'd1;
                            end else begin
                                pin_mid_q <= 1'b1; // R23
                                tmr_q <= T_ACTIVE;
                                st_q <= S_PULSE;
                                step_q <= step_q + 5'd1;
                            end
                        end else begin
                            pin_high_q <= 1'b1;
                            tmr_q <= (cur_kind == P_BLOW) ? T_BLOW : T_ACTIVE; // R10
                            st_q <= S_PULSE;
                            step_q <= step_q + 5'd1;
                        end
                    end
                end
                S_PULSE: begin
                    if (tmr_q != 32'h0) begin
                        tmr_q <= tmr_q - 32'h1;
                    end else begin
                        pin_mid_q <= 1'b0;
                        pin_high_q <= 1'b0;
                        if (kind_q == P_BLOW && cmd_q == `PFP_CMD_LOCK)
                            lock_sent_q <= 1'b1; // R14
                        tmr_q <= T_LOW; // R19: gap also after a blow
                        st_q <= S_GAP;
                    end
                end
                S_HELD: begin
                    // R10 R17: software powers off before the next job
                    if (reg_wr && reg_addr == `PFP_REG_CTRL && reg_wdata[2:0] == 3'h0) begin
                        power_on_q <= 1'b0;
                        st_q <= S_DONE;
                        tmr_q <= T_LOW;
                    end
                end
                S_DONE: begin
                    if (tmr_q != 32'h0) begin
                        tmr_q <= tmr_q - 32'h1;
                    end else begin
                        busy_q <= 1'b0;
                        held_q <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // read data one cycle after the strobe
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_q <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `PFP_REG_CTRL: reg_rdata_q <= {29'h0, cmd_q};
                `PFP_REG_ARG: reg_rdata_q <= {8'h0, code2_q, code_q, 4'h0, key_q, zone_q};
                `PFP_REG_STAT: reg_rdata_q <= {26'h0, st_q == S_HELD, lock_sent_q, held_q, power_on_q,
                    pin_high_q, busy_q};
                default: reg_rdata_q <= 32'h0;
            endcase
        end else begin
            reg_rdata_q <= 32'h0;
        end
    end
endmodule

// ==== pfp_ctrl_monitor.sv ====
// port checker for the pulse programmer
`timescale 1ns/1ps
module pfp_ctrl_monitor #(parameter T_ACTIVE = 5, parameter T_LOW = 5, parameter T_BLOW = 5) (
    // clock, reset and register port
    input wire mclk,
    input wire rst_b,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_q,
    // pin drive
    input wire pin_mid_q,
    input wire pin_high_q,
    input wire power_on_q
);
    wire lvl = pin_mid_q | pin_high_q;
    wire off_wr = reg_wr && reg_addr == 4'h0 && reg_wdata[2:0] == 3'h0;
    wire stat_rd = reg_rd && reg_addr == 4'h2;
    reg [15:0] run_q;
    reg [15:0] gap_q;
    // pulse and gap lengths; the gap only counts while powered
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            run_q <= 16'h0;
            gap_q <= 16'h0;
        end else begin
            run_q <= lvl ? run_q + 16'h1 : 16'h0;
            gap_q <= (power_on_q && !lvl) ? gap_q + 16'h1 : 16'h0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_one_level: assert property (!(pin_mid_q && pin_high_q)) else $error("mid and high together");
    a_level_powered: assert property (lvl |-> power_on_q) else $error("pulse without supply");
    a_mid_width: assert property ($fell(pin_mid_q) |-> run_q == T_ACTIVE + 1) else $error("mid width");
    a_high_width: assert property ($fell(pin_high_q) |-> run_q == T_ACTIVE + 1 || run_q == T_BLOW + 1)
        else $error("high width");
    a_gap_min: assert property ($rose(lvl) |-> gap_q >= T_LOW + 1) else $error("gap too short");
    a_gap_before_off: assert property ($fell(power_on_q) |-> gap_q >= T_LOW + 1) else $error("off too soon");
    a_off_by_cmd: assert property ($fell(power_on_q) |-> $past(off_wr) || $past(off_wr, 2))
        else $error("supply dropped unasked");
    a_held_quiet: assert property ($past(stat_rd) && reg_rdata_q[5] |-> !lvl) else $error("pulse while held");
    c_mid: cover property ($fell(pin_mid_q));
    c_blow: cover property ($fell(pin_high_q) && run_q == T_BLOW + 1);
    c_off: cover property ($fell(power_on_q));
endmodule
bind pfp_ctrl pfp_ctrl_monitor #(.T_ACTIVE(T_ACTIVE), .T_LOW(T_LOW), .T_BLOW(T_BLOW)) i_pfp_ctrl_monitor (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .pin_mid_q(pin_mid_q), .pin_high_q(pin_high_q), .power_on_q(power_on_q));

// ==== pfp_map.vh ====
// constants for the pulse fuse programmer
`ifndef PFP_MAP_VH
`define PFP_MAP_VH
`define PFP_CLK_MHZ 100
`define PFP_T_ACTIVE_US 40
`define PFP_T_LOW_US 40
`define PFP_T_BLOW_US 40
`define PFP_T_ACTIVE_CYC (`PFP_T_ACTIVE_US * `PFP_CLK_MHZ)
`define PFP_T_LOW_CYC (`PFP_T_LOW_US * `PFP_CLK_MHZ)
`define PFP_T_BLOW_CYC (`PFP_T_BLOW_US * `PFP_CLK_MHZ)
`define PFP_REG_CTRL 4'h0
`define PFP_REG_ARG 4'h1
`define PFP_REG_STAT 4'h2
`define PFP_CMD_TRY 3'h1
`define PFP_CMD_BLOW 3'h2
`define PFP_CMD_LOCK 3'h3
`define PFP_CMD_HOLD 3'h4
`define PFP_LOCK_KEY 2'h2
`define PFP_LOCK_CODE 8'h04
`define PFP_MAX_CODE 8'hff
`endif

// ==== pfp_sensor_model.sv ====
// behavioural sensor: pulse decoder, trial codes and fuses
`timescale 1ns/1ps
module pfp_sensor_model (
    // pin levels from the programmer
    input wire logic mclk,
    input wire logic pin_mid,
    input wire logic pin_high,
    input wire logic power_on,
    // codes: 0 gain, 1 fine level, 2 coarse level and lock
    output logic [7:0] trial_q [3],
    output logic [7:0] fuse_q [3]
);
    logic [1:0] prev_q = 2'h0;
    logic [2:0] st_q;
    logic [1:0] key_q;
    logic [1:0] sel_q;
    // act on a pulse only once the pin is back low; codes rest between pulses
    wire [1:0] ev = ({pin_high, pin_mid} == 2'h0) ? prev_q : 2'h0;
    // fuses start intact and survive every power cycle
    initial fuse_q = '{3{8'h00}};
    // states: 0 initial, 1 zone one, 2 skipped, 3 zone two, 4 addressing, 5 blow armed, 6 done
    always @(posedge mclk) begin
        prev_q <= {pin_high, pin_mid};
        if (!power_on) begin
            st_q <= 3'h0;
            key_q <= 2'h0;
            trial_q <= '{3{8'h00}};
        end else if (fuse_q[2][2]) begin
            st_q <= 3'h6;
        end else if (ev == 2'h1) begin
            if (st_q == 3'h1 || st_q == 3'h3) key_q <= key_q + 2'h1;
            if (st_q == 3'h4 && trial_q[sel_q] != 8'hff) trial_q[sel_q] <= trial_q[sel_q] + 8'h01;
        end else if (ev == 2'h2) begin
            key_q <= 2'h0;
            sel_q <= (st_q == 3'h1) ? 2'h0 : key_q;
            case (st_q)
                3'h0: st_q <= 3'h1;
                3'h1: st_q <= (key_q == 2'h0) ? 3'h2 : 3'h4;
                3'h2: st_q <= 3'h3;
                3'h3: st_q <= (key_q == 2'h0) ? 3'h5 : 3'h4;
                3'h4: st_q <= (sel_q == 2'h0) ? 3'h3 : 3'h6;
                default: st_q <= 3'h6;
            endcase
            if (st_q == 3'h4 && sel_q != 2'h0) fuse_q[sel_q] <= fuse_q[sel_q] | trial_q[sel_q];
            if (st_q == 3'h5) fuse_q[0] <= fuse_q[0] | trial_q[0];
        end
    end
endmodule

// ==== tb_pfp_ctrl.sv ====
// self-checking bench: register jobs against the sensor model
`timescale 1ns/1ps
module tb_pfp_ctrl;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata_q;
    logic pin_mid_q, pin_high_q, power_on_q;
    logic [7:0] trial [3];
    logic [7:0] fuse [3];
    logic [31:0] s;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    // short counts keep the long codes quick
    pfp_ctrl #(.T_ACTIVE(5), .T_LOW(5), .T_BLOW(5)) i_pfp_ctrl (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .pin_mid_q(pin_mid_q), .pin_high_q(pin_high_q), .power_on_q(power_on_q));
    pfp_sensor_model i_pfp_sensor_model (.mclk(mclk), .pin_mid(pin_mid_q), .pin_high(pin_high_q),
        .power_on(power_on_q), .trial_q(trial), .fuse_q(fuse));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // hang guard, well above the longest job
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
    function logic [31:0] arg(input logic [1:0] z, input logic [1:0] k, input logic [7:0] c, input logic [7:0] c2);
        arg = {8'h00, c2, c, 4'h0, k, z};
    endfunction
    // start a job and poll until the sequencer reaches its held state (status bit 5) with supply on
    task job(input logic [2:0] c, input logic [31:0] a);
        int n;
        wr(4'h1, a);
        wr(4'h0, {29'h0, c});
        n = 0;
        s = 32'h0;
        while (s[5] !== 1'b1 && n < 3000) begin
            rd(4'h2, s);
            n++;
        end
        chk(s[5], 1'b1);
    endtask
    // power off, then wait for busy to drop
    task off();
        int n;
        wr(4'h0, 32'h0);
        n = 0;
        s = 32'h1;
        while (s[0] !== 1'b0 && n < 100) begin
            rd(4'h2, s);
            n++;
        end
        chk(s[0], 1'b0);
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        rd(4'h2, s);
        chk(s, 32'h0);
        rd(4'hf, s);
        chk(s, 32'h0);
        $display("test reset done");
        job(3'h1, arg(2'h1, 2'h1, 8'h03, 8'h00));
        chk(trial[0], 8'h03);
        chk(s[5:2], 4'hb);
        off();
        chk(trial[0], 8'h00);
        job(3'h1, arg(2'h1, 2'h1, 8'h00, 8'h00));
        chk(trial[0], 8'h00);
        off();
        job(3'h1, arg(2'h2, 2'h1, 8'hff, 8'h00));
        chk({trial[0], trial[1]}, 16'h00ff);
        off();
        job(3'h1, arg(2'h2, 2'h2, 8'h01, 8'h00));
        chk(trial[2], 8'h01);
        off();
        $display("test try done");
        job(3'h4, arg(2'h1, 2'h1, 8'h07, 8'h09));
        chk({trial[0], trial[1]}, 16'h0709);
        off();
        $display("test hold done");
        job(3'h2, arg(2'h1, 2'h1, 8'h04, 8'h00));
        off();
        job(3'h2, arg(2'h1, 2'h1, 8'h01, 8'h00));
        off();
        chk(fuse[0], 8'h05);
        job(3'h2, arg(2'h2, 2'h1, 8'h02, 8'h00));
        off();
        chk(fuse[1], 8'h02);
        $display("test blow done");
        job(3'h3, 32'h0);
        chk({fuse[2], s[4]}, 9'h009);
        off();
        wr(4'h0, 32'h1);
        rd(4'h2, s);
        chk(s[2:0], 3'h0);
        $display("test lock done");
        give_verdict();
    end
endmodule
